// ---- tape_xport_map.vh ----
// Register offsets, field positions, reset values and timing constants of the tape transport interface
`ifndef TAPE_XPORT_MAP_VH
`define TAPE_XPORT_MAP_VH
`define ADDR_CMD 4'h0
`define ADDR_STAT 4'h1
`define ADDR_WDATA 4'h2
`define ADDR_RDATA 4'h3
`define ADDR_IRQ_STAT 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_CFG 4'h6
`define CMD_UNIT_HI 2
`define CMD_UNIT_LO 0
`define CMD_DUMP 4
`define CMD_OP_HI 8
`define CMD_OP_LO 6
`define CMD_DEN_HI 11
`define CMD_DEN_LO 10
`define OP_NOOP 3'h0
`define OP_REWIND 3'h1
`define OP_READ 3'h2
`define OP_CMP 3'h3
`define OP_WRITE 3'h4
`define OP_WEOF 3'h5
`define OP_SPFWD 3'h6
`define OP_SPREV 3'h7
`define DEN_800_9 2'h3
`define CMD_RESET 12'h000
`define MASK_RESET 8'h00
`define EV_DONE 0
`define EV_ILLEGAL 1
`define EV_CMP_ERR 2
`define EV_EOT 3
`define EV_BOT 4
`define EV_WREQ 5
`define EV_RDATA 6
`define EV_DUMP_ERR 7
`define EV_W 8
`define CLK_MHZ 125
`define READ_STOP_US 3600
`define WRITE_STOP_US 4500
`define READ_STOP_CYC ((`READ_STOP_US * `CLK_MHZ))
`define WRITE_STOP_CYC ((`WRITE_STOP_US * `CLK_MHZ))
`define CNT_W 20
`define PULSE_DIV 8'hff
`endif

// ---- tape_xport.v ----
// Tape transport interface: transport selection, character formats, motion sequencing and shutdown delays
`timescale 1ns/100ps
`include "tape_xport_map.vh"
//
// Operation
// - Selected unit's track count sets seven- or nine-track character handling.
// - Nine-track compare ignores tape parity and memory word bits 8 to 11.
// - Core dump mode needs a nine-track unit and command bit 4.
// - Core dump writes each word as two six-bit characters on seven tracks.
// - Writing asserts forward motion and write enable, one record pulse per character.
// - Spacing and reading drive motion only, no write enable, no record pulses.
// - Transport always returns read data; end of record ends the operation.
// - Seven-track allows 200, 556, 800 bpi; nine-track only 800 bpi.
// - Seven-track: six data bits plus parity; nine-track: eight plus parity.
// - Local motion runs until reset, going online, BOT on reverse or rewind, or EOT going forward.
// - Offline enables local controls; online acts only when selected.
// - Ready only with vacuum on, settle done and no motion.
// - Missing write ring reports write lock and blocks writing.
// - Shutdown delay 3.6 ms after read or compare, about 4.5 ms after write.
// - Unit selected by matching its unit number to the command unit field.
// - Write to a write-locked unit is rejected as illegal command.
module tape_xport #(
  parameter READ_STOP = `READ_STOP_CYC,
  parameter WRITE_STOP = `WRITE_STOP_CYC
)(
  input wire mclk,
  input wire rst,
  input wire [3:0] addr,
  input wire [11:0] wdata,
  input wire wr,
  input wire rd,
  output reg [11:0] rdata_ff,
  output wire irq,
  input wire [23:0] unit_num,
  input wire [7:0] nine_track,
  input wire [7:0] vacuum_on,
  input wire [7:0] settled,
  input wire [7:0] ring_present,
  input wire [7:0] online,
  input wire [7:0] at_bot,
  input wire [7:0] at_eot,
  input wire [7:0] panel_fwd,
  input wire [7:0] panel_rev,
  input wire [7:0] panel_rewind,
  input wire [7:0] panel_reset,
  input wire [8:0] read_char,
  input wire read_strobe,
  input wire end_of_record,
  output reg [7:0] forward_motion_ff,
  output reg [7:0] backward_motion_ff,
  output reg [7:0] rewind_ff,
  output reg [7:0] write_enable_ff,
  output reg [7:0] record_pulse_ff,
  output reg [8:0] write_char_ff,
  output reg [1:0] density_ff,
  output wire [7:0] ready,
  output wire [7:0] write_lock
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_STOP = 2'h2;

  reg [11:0] cmd_ff;
  reg [11:0] wword_ff;
  reg wfull_ff;
  reg [11:0] rword_ff;
  reg [1:0] st_ff;
  reg [`CNT_W-1:0] cnt_ff;
  reg half_ff;
  reg [7:0] pdiv_ff;
  reg [8:0] istat_ff;
  reg [8:0] imask_ff;
  reg [7:0] lmove_ff;
  reg [7:0] lfwd_ff;
  reg [7:0] lrev_ff;
  reg [7:0] lrew_ff;
  reg [7:0] s1_ff [0:11];
  reg [7:0] s2_ff [0:11];
  reg [10:0] rs1_ff;
  reg [10:0] rs2_ff;
  reg rs3_ff;
  reg eor3_ff;
  reg [8:0] nxt_ev;

  wire [7:0] p_nine = s2_ff[0];
  wire [7:0] p_vac = s2_ff[1];
  wire [7:0] p_set = s2_ff[2];
  wire [7:0] p_ring = s2_ff[3];
  wire [7:0] p_onl = s2_ff[4];
  wire [7:0] p_bot = s2_ff[5];
  wire [7:0] p_eot = s2_ff[6];
  wire [7:0] p_fwd = s2_ff[7];
  wire [7:0] p_rev = s2_ff[8];
  wire [7:0] p_rew = s2_ff[9];
  wire [7:0] p_rst = s2_ff[10];
  wire [8:0] r_char = rs2_ff[8:0];
  wire r_stb = rs2_ff[9] & ~rs3_ff;
  wire r_eor = rs2_ff[10] & ~eor3_ff;

  wire [2:0] cmd_unit = cmd_ff[`CMD_UNIT_HI:`CMD_UNIT_LO];
  wire [2:0] cmd_op = cmd_ff[`CMD_OP_HI:`CMD_OP_LO];
  wire [1:0] cmd_den = cmd_ff[`CMD_DEN_HI:`CMD_DEN_LO];
  wire [7:0] sel_vec;
  wire [7:0] new_sel;
  wire [7:0] moving = forward_motion_ff | backward_motion_ff | rewind_ff;
  wire any_sel = |sel_vec;
  wire sel_nine = |(sel_vec & p_nine);
  wire sel_lock = |(sel_vec & write_lock);
  wire sel_ready = |(sel_vec & ready);
  wire sel_bot = |(sel_vec & p_bot);
  wire sel_eot = |(sel_vec & p_eot);
  wire dump = cmd_ff[`CMD_DUMP] & sel_nine;
  wire narrow = ~sel_nine | dump;
  wire is_write = (cmd_op == `OP_WRITE) | (cmd_op == `OP_WEOF);
  wire is_cmp = cmd_op == `OP_CMP;
  wire is_rev = (cmd_op == `OP_SPREV) | (cmd_op == `OP_REWIND);
  wire den_bad = sel_nine ? (cmd_den != `DEN_800_9) : (cmd_den == `DEN_800_9);
  wire start = wr & (addr == `ADDR_CMD);
  wire bad_dump = wdata[`CMD_DUMP] & ~|(new_sel & p_nine);
  wire pulse_tick = pdiv_ff == `PULSE_DIV;
  wire [11:0] nine_cmp_mask = 12'h0ff;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : unit
      assign sel_vec[g] = (unit_num[3*g+2:3*g] == cmd_unit) & p_onl[g];
      assign new_sel[g] = (unit_num[3*g+2:3*g] == wdata[`CMD_UNIT_HI:`CMD_UNIT_LO]) & p_onl[g];
      assign ready[g] = p_vac[g] & p_set[g] & ~moving[g];
      assign write_lock[g] = ~p_ring[g];
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          lfwd_ff[g] <= 1'b0;
          lrev_ff[g] <= 1'b0;
          lrew_ff[g] <= 1'b0;
        end
        else if (p_onl[g] | p_rst[g])
        begin
          lfwd_ff[g] <= 1'b0;
          lrev_ff[g] <= 1'b0;
          lrew_ff[g] <= 1'b0;
        end
        else
        begin
          lfwd_ff[g] <= (lfwd_ff[g] | p_fwd[g]) & ~p_eot[g];
          lrev_ff[g] <= (lrev_ff[g] | p_rev[g]) & ~p_bot[g];
          lrew_ff[g] <= (lrew_ff[g] | p_rew[g]) & ~p_bot[g];
        end
      end
    end
    for (g = 0; g < 12; g = g + 1)
    begin : sync
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          s1_ff[g] <= 8'h00;
          s2_ff[g] <= 8'h00;
        end
        else
        begin
          s1_ff[g] <= (g == 0) ? nine_track : (g == 1) ? vacuum_on : (g == 2) ? settled :
            (g == 3) ? ring_present : (g == 4) ? online : (g == 5) ? at_bot : (g == 6) ? at_eot :
            (g == 7) ? panel_fwd : (g == 8) ? panel_rev : (g == 9) ? panel_rewind :
            (g == 10) ? panel_reset : 8'h00;
          s2_ff[g] <= s1_ff[g];
        end
      end
    end
  endgenerate

  always @*
  begin
    nxt_ev = 9'h000;
    if (start & (bad_dump | (st_ff != ST_IDLE)))
      nxt_ev[`EV_ILLEGAL] = 1'b1;
    if (bad_dump & start)
      nxt_ev[`EV_DUMP_ERR] = 1'b1;
    if ((st_ff == ST_STOP) & (cnt_ff == {`CNT_W{1'b0}}))
      nxt_ev[`EV_DONE] = 1'b1;
    if ((st_ff == ST_IDLE) & (cmd_op != `OP_NOOP) & (~any_sel | ~sel_ready | den_bad | (is_write & sel_lock) |
      (is_rev & sel_bot)) & lmove_ff[0])
      nxt_ev[`EV_ILLEGAL] = 1'b1;
    if ((st_ff == ST_RUN) & r_stb & is_cmp & ~is_write)
      if (narrow ? (r_char[5:0] != (half_ff ? wword_ff[5:0] : wword_ff[11:6])) :
        ((r_char[7:0] & nine_cmp_mask[7:0]) != wword_ff[7:0]))
        nxt_ev[`EV_CMP_ERR] = 1'b1;
    if ((st_ff == ST_RUN) & sel_eot & ~is_rev)
      nxt_ev[`EV_EOT] = 1'b1;
    if ((st_ff == ST_RUN) & sel_bot & is_rev)
      nxt_ev[`EV_BOT] = 1'b1;
    if ((st_ff == ST_RUN) & is_write & ~wfull_ff)
      nxt_ev[`EV_WREQ] = 1'b1;
    if ((st_ff == ST_RUN) & r_stb & ~is_write & (~narrow | half_ff))
      nxt_ev[`EV_RDATA] = 1'b1;
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmd_ff <= `CMD_RESET;
      wword_ff <= 12'h000;
      wfull_ff <= 1'b0;
      rword_ff <= 12'h000;
      st_ff <= ST_IDLE;
      cnt_ff <= {`CNT_W{1'b0}};
      half_ff <= 1'b0;
      pdiv_ff <= 8'h00;
      istat_ff <= 9'h000;
      imask_ff <= {1'b0, `MASK_RESET};
      lmove_ff <= 8'h00;
      rs1_ff <= 11'h000;
      rs2_ff <= 11'h000;
      rs3_ff <= 1'b0;
      eor3_ff <= 1'b0;
      forward_motion_ff <= 8'h00;
      backward_motion_ff <= 8'h00;
      rewind_ff <= 8'h00;
      write_enable_ff <= 8'h00;
      record_pulse_ff <= 8'h00;
      write_char_ff <= 9'h000;
      density_ff <= 2'h0;
      rdata_ff <= 12'h000;
    end
    else
    begin
      rs1_ff <= {end_of_record, read_strobe, read_char};
      rs2_ff <= rs1_ff;
      rs3_ff <= rs2_ff[9];
      eor3_ff <= rs2_ff[10];
      pdiv_ff <= pulse_tick ? 8'h00 : pdiv_ff + 8'h01;
      record_pulse_ff <= 8'h00;
      lmove_ff <= {7'h00, 1'b0};
      istat_ff <= (istat_ff & ~((wr & (addr == `ADDR_IRQ_STAT)) ? wdata[8:0] : 9'h000)) | nxt_ev;
      if (wr & (addr == `ADDR_IRQ_MASK))
        imask_ff <= wdata[8:0];
      if (wr & (addr == `ADDR_WDATA))
      begin
        wword_ff <= wdata;
        wfull_ff <= 1'b1;
        half_ff <= 1'b0;
      end
      if (start & (st_ff == ST_IDLE) & ~bad_dump)
      begin
        cmd_ff <= wdata;
        lmove_ff <= 8'h01;
      end
      density_ff <= cmd_den;
      rdata_ff <= 12'h000;
      if (rd)
        case (addr)
          `ADDR_CMD: rdata_ff <= cmd_ff;
          `ADDR_STAT: rdata_ff <= {1'b0, dump, sel_nine, sel_lock, sel_ready, sel_bot, sel_eot, any_sel, 2'h0, st_ff};
          `ADDR_RDATA: rdata_ff <= rword_ff;
          `ADDR_IRQ_STAT: rdata_ff <= {3'h0, istat_ff};
          `ADDR_IRQ_MASK: rdata_ff <= {3'h0, imask_ff};
          default: rdata_ff <= 12'h000;
        endcase
      case (st_ff)
        ST_IDLE:
        begin
          forward_motion_ff <= lfwd_ff;
          backward_motion_ff <= lrev_ff;
          rewind_ff <= lrew_ff;
          write_enable_ff <= 8'h00;
          if (lmove_ff[0] & (cmd_op != `OP_NOOP) & any_sel & sel_ready & ~den_bad & ~(is_write & sel_lock) &
            ~(is_rev & sel_bot))
          begin
            st_ff <= ST_RUN;
            half_ff <= 1'b0;
            forward_motion_ff <= lfwd_ff | (is_rev ? 8'h00 : sel_vec);
            backward_motion_ff <= lrev_ff | ((cmd_op == `OP_SPREV) ? sel_vec : 8'h00);
            rewind_ff <= lrew_ff | ((cmd_op == `OP_REWIND) ? sel_vec : 8'h00);
            write_enable_ff <= is_write ? sel_vec : 8'h00;
          end
        end
        ST_RUN:
        begin
          if (is_write & wfull_ff & pulse_tick)
          begin
            record_pulse_ff <= sel_vec;
            if (narrow)
            begin
              write_char_ff <= {2'h0, ~^(half_ff ? wword_ff[5:0] : wword_ff[11:6]),
                half_ff ? wword_ff[5:0] : wword_ff[11:6]};
              half_ff <= ~half_ff;
              wfull_ff <= ~half_ff;
            end
            else
            begin
              write_char_ff <= {~^wword_ff[7:0], wword_ff[7:0]};
              wfull_ff <= 1'b0;
            end
          end
          if (r_stb & ~is_write)
          begin
            if (narrow)
            begin
              rword_ff <= half_ff ? {rword_ff[11:6], r_char[5:0]} : {r_char[5:0], 6'h00};
              half_ff <= ~half_ff;
            end
            else
              rword_ff <= {4'h0, r_char[7:0]};
          end
          if (r_eor | (is_rev & sel_bot) | ((cmd_op == `OP_REWIND) & sel_bot))
          begin
            st_ff <= ST_STOP;
            cnt_ff <= is_write ? WRITE_STOP[`CNT_W-1:0] : READ_STOP[`CNT_W-1:0];
          end
        end
        ST_STOP:
        begin
          write_enable_ff <= 8'h00;
          if (cnt_ff == {`CNT_W{1'b0}})
          begin
            st_ff <= ST_IDLE;
            forward_motion_ff <= 8'h00;
            backward_motion_ff <= 8'h00;
            rewind_ff <= 8'h00;
          end
          else
            cnt_ff <= cnt_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  assign irq = |(istat_ff & imask_ff);
endmodule

// ---- tape_xport_props.sv ----
// Port checker of the tape transport interface
`timescale 1ns/100ps
module tape_xport_props #(
  parameter READ_STOP = 20,
  parameter WRITE_STOP = 30
)(
  input wire mclk,
  input wire rst,
  input wire rd,
  input wire [11:0] rdata_ff,
  input wire [7:0] nine_track,
  input wire end_of_record,
  input wire [7:0] forward_motion_ff,
  input wire [7:0] backward_motion_ff,
  input wire [7:0] rewind_ff,
  input wire [7:0] write_enable_ff,
  input wire [7:0] record_pulse_ff,
  input wire [8:0] write_char_ff,
  input wire [1:0] density_ff,
  input wire [7:0] ready,
  input wire [7:0] write_lock
);
  localparam int RS = READ_STOP;
  localparam int WS = WRITE_STOP;
  wire [7:0] mot = forward_motion_ff | backward_motion_ff;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence rd_eor;
    $rose(end_of_record) && mot != 8'h00 && write_enable_ff == 8'h00;
  endsequence
  sequence wr_eor;
    $rose(end_of_record) && write_enable_ff != 8'h00;
  endsequence
  sequence stop_tail;
    (mot != 8'h00) ##[1:12] (mot == 8'h00);
  endsequence
  a_pulse_fwd_we: assert property ((record_pulse_ff & ~(write_enable_ff & forward_motion_ff)) == 8'h00)
    else $error("record pulse without forward write");
  a_pulse_single: assert property (record_pulse_ff != 8'h00 |=> record_pulse_ff == 8'h00)
    else $error("record pulse too long");
  a_rev_no_we: assert property (backward_motion_ff != 8'h00 |-> (write_enable_ff | record_pulse_ff) == 8'h00)
    else $error("write drive during reverse");
  a_one_unit: assert property ($onehot0(mot | write_enable_ff))
    else $error("more than one unit driven");
  a_ready_still: assert property ((ready & (mot | rewind_ff)) == 8'h00)
    else $error("ready while moving");
  a_lock_no_we: assert property ((write_enable_ff & write_lock) == 8'h00)
    else $error("write enable on locked unit");
  a_nine_density: assert property ((mot & nine_track) != 8'h00 |-> density_ff == 2'h3)
    else $error("nine-track unit moving at wrong density");
  a_char_parity: assert property (record_pulse_ff != 8'h00 |-> (^write_char_ff) == 1'b1)
    else $error("written character parity not odd");
  a_read_stop: assert property (rd_eor |-> ##RS stop_tail)
    else $error("read shutdown delay wrong");
  a_write_stop: assert property (wr_eor |-> ##WS stop_tail)
    else $error("write shutdown delay wrong");
  a_rdata_idle: assert property (!$past(rd) |-> rdata_ff == 12'h000)
    else $error("read data outside answer cycle");
endmodule
bind tape_xport tape_xport_props #(.READ_STOP(READ_STOP), .WRITE_STOP(WRITE_STOP)) u_props (.mclk(mclk),
  .rst(rst), .rd(rd), .rdata_ff(rdata_ff), .nine_track(nine_track), .end_of_record(end_of_record),
  .forward_motion_ff(forward_motion_ff), .backward_motion_ff(backward_motion_ff), .rewind_ff(rewind_ff),
  .write_enable_ff(write_enable_ff), .record_pulse_ff(record_pulse_ff), .write_char_ff(write_char_ff),
  .density_ff(density_ff), .ready(ready), .write_lock(write_lock));

// ---- tape_unit_model.sv ----
// Transport stand-in: returns read characters and end of record while tape moves
`timescale 1ns/100ps
module tape_unit_model (
  input wire mclk,
  input wire [7:0] forward_motion_ff,
  input wire [7:0] backward_motion_ff,
  input wire [7:0] write_enable_ff,
  input wire [7:0] record_pulse_ff,
  input wire [8:0] write_char_ff,
  input wire nine_sel,
  output reg [8:0] read_char = 9'h000,
  output reg read_strobe = 1'b0,
  output reg end_of_record = 1'b0
);
  reg [4:0] tick = 5'h00;
  reg [1:0] nch = 2'h0;
  wire moving = (forward_motion_ff | backward_motion_ff) != 8'h00;
  wire wmode = write_enable_ff != 8'h00;
  wire [7:0] dat = (nch == 2'h0) ? 8'h15 : 8'h2a;
  always @(posedge mclk)
  begin
    tick <= tick + 5'h01;
    read_strobe <= 1'b0;
    read_char <= ~read_char; // Stale data never looks valid
    if (!moving)
    begin
      nch <= 2'h0;
      end_of_record <= 1'b0;
    end
    else if (nch == 2'h2)
      end_of_record <= 1'b1; // Record ends after two characters
    else if (wmode ? record_pulse_ff != 8'h00 : tick == 5'h1f)
    begin
      read_char <= wmode ? write_char_ff : (nine_sel ? {~^dat, dat} : {2'b00, ~^dat[5:0], dat[5:0]});
      read_strobe <= 1'b1;
      nch <= nch + 2'h1;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench of the tape transport interface
`timescale 1ns/100ps
`include "tape_xport_map.vh"
module testbench;
  typedef struct packed {logic [11:0] cmd; logic [1:0] kind; logic [2:0] u; logic [7:0] ev;} row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic nine_sel = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [11:0] wdata = 12'h000;
  logic [7:0] at_bot = 8'h00;
  logic [23:0] unit_num = 24'h053977;
  logic [7:0] nine_track = 8'h02;
  logic [7:0] vacuum_on = 8'hff;
  logic [7:0] settled = 8'hef;
  logic [7:0] ring_present = 8'hfb;
  logic [7:0] online = 8'hf7;
  logic [7:0] at_eot = 8'h00;
  logic [7:0] panel_fwd = 8'h00;
  logic [7:0] panel_rev = 8'h00;
  logic [7:0] panel_rewind = 8'h00;
  logic [7:0] panel_reset = 8'h00;
  logic [11:0] d;
  wire [11:0] rdata_ff;
  wire irq;
  wire [8:0] read_char;
  wire read_strobe;
  wire end_of_record;
  wire [7:0] forward_motion_ff, backward_motion_ff, rewind_ff, write_enable_ff, record_pulse_ff, ready, write_lock;
  wire [8:0] write_char_ff;
  wire [1:0] density_ff;
  int bad_count = 0;
  int num_checks = 0;
  logic [8:0] wq [$];
  row_t rows [12] = '{'{12'h087, 2'h1, 3'h0, 8'h01}, '{12'h587, 2'h1, 3'h0, 8'h01}, '{12'hcc6, 2'h1, 3'h1, 8'h01},
    '{12'h886, 2'h0, 3'h1, 8'h02}, '{12'h105, 2'h0, 3'h2, 8'h02}, '{12'h084, 2'h0, 3'h3, 8'h02},
    '{12'h083, 2'h0, 3'h4, 8'h02}, '{12'h117, 2'h0, 3'h0, 8'h82}, '{12'h907, 2'h2, 3'h0, 8'h01},
    '{12'hd16, 2'h2, 3'h1, 8'h01}, '{12'h1c7, 2'h3, 3'h0, 8'h01},
    '{12'hc96, 2'h1, 3'h1, 8'h01}}; // Dump tape read back in dump mode
  always #4 mclk = ~mclk;
  always @(negedge mclk)
    if (record_pulse_ff != 8'h00)
      wq.push_back(write_char_ff);
  tape_xport #(.READ_STOP(20), .WRITE_STOP(30)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .irq(irq), .unit_num(unit_num), .nine_track(nine_track),
    .vacuum_on(vacuum_on), .settled(settled), .ring_present(ring_present), .online(online), .at_bot(at_bot),
    .at_eot(at_eot), .panel_fwd(panel_fwd), .panel_rev(panel_rev), .panel_rewind(panel_rewind),
    .panel_reset(panel_reset),
    .read_char(read_char), .read_strobe(read_strobe), .end_of_record(end_of_record),
    .forward_motion_ff(forward_motion_ff), .backward_motion_ff(backward_motion_ff), .rewind_ff(rewind_ff),
    .write_enable_ff(write_enable_ff), .record_pulse_ff(record_pulse_ff), .write_char_ff(write_char_ff),
    .density_ff(density_ff), .ready(ready), .write_lock(write_lock));
  tape_unit_model model (.mclk(mclk), .forward_motion_ff(forward_motion_ff),
    .backward_motion_ff(backward_motion_ff), .write_enable_ff(write_enable_ff),
    .record_pulse_ff(record_pulse_ff), .write_char_ff(write_char_ff), .nine_sel(nine_sel),
    .read_char(read_char), .read_strobe(read_strobe), .end_of_record(end_of_record));
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input string n, input logic [11:0] got, input logic [11:0] exp);
    begin
      num_checks++;
      if (got !== exp)
      begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
    end
  endtask
  task bus_wr(input logic [3:0] a, input logic [11:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task bus_rd(input logic [3:0] a, output logic [11:0] v);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      v = rdata_ff;
    end
  endtask
  task wait_irq;
    int i;
    begin
      for (i = 0; i < 3000 && irq !== 1'b1; i++)
        @(posedge mclk);
      if (i == 3000)
      begin
        bad_count++;
        report_and_stop;
      end
    end
  endtask
  task start(input logic [11:0] c, input logic [7:0] ev);
    begin
      bus_wr(`ADDR_CMD, c);
      wait_irq();
      bus_rd(`ADDR_IRQ_STAT, d);
      chk("event", d & 12'h083, {4'h0, ev});
      bus_wr(`ADDR_IRQ_STAT, 12'h0ff);
    end
  endtask
  task run_row(input row_t r);
    logic [7:0] b;
    begin
      b = 8'h01 << r.u;
      wq.delete();
      nine_sel <= r.u == 3'h1;
      bus_wr(`ADDR_WDATA, 12'ha5c);
      fork
        start(r.cmd, r.ev);
        begin
          repeat (6) @(posedge mclk);
          chk("fwd", forward_motion_ff, (r.kind == 2'h1 || r.kind == 2'h2) ? b : 8'h00);
          chk("wen", write_enable_ff, r.kind == 2'h2 ? b : 8'h00);
          chk("rev", backward_motion_ff, r.kind == 2'h3 ? b : 8'h00);
        end
      join
      chk("stopped", forward_motion_ff | backward_motion_ff, 8'h00);
      if (r.kind == 2'h2)
      begin
        chk("nchar", 12'(wq.size()), 12'h002);
        chk("char0", wq[0], 9'h029);
        chk("char1", wq[1], 9'h01c);
      end
      if (r.cmd[`CMD_OP_HI:`CMD_OP_LO] == `OP_READ && r.kind == 2'h1)
      begin
        bus_rd(`ADDR_RDATA, d);
        chk("rword", d, 12'h56a);
      end
    end
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    bus_rd(`ADDR_CMD, d);
    chk("cmd reset", d, `CMD_RESET);
    bus_rd(`ADDR_IRQ_MASK, d);
    chk("mask reset", d, {4'h0, `MASK_RESET});
    bus_rd(4'hf, d);
    chk("unmapped", d, 12'h000);
    bus_wr(`ADDR_IRQ_MASK, 12'h083);
    foreach (rows[i])
      run_row(rows[i]);
    bus_wr(`ADDR_CMD, 12'h047);
    repeat (4) @(posedge mclk);
    chk("rewind", rewind_ff, 8'h01);
    at_bot <= 8'h01;
    wait_irq();
    chk("rewind end", rewind_ff, 8'h00);
    bus_wr(`ADDR_IRQ_STAT, 12'h0ff);
    start(12'h1c7, 8'h02);
    at_bot <= 8'h00;
    bus_wr(`ADDR_CMD, 12'h007);
    repeat (8) @(posedge mclk);
    bus_rd(`ADDR_IRQ_STAT, d);
    chk("noop", d, 12'h000);
    bus_wr(`ADDR_IRQ_MASK, 12'h000);
    bus_wr(`ADDR_CMD, 12'h105);
    repeat (8) @(posedge mclk);
    chk("masked", irq, 1'b0);
    bus_wr(`ADDR_IRQ_MASK, 12'h002);
    chk("unmasked", irq, 1'b1);
    bus_wr(`ADDR_IRQ_STAT, 12'h002);
    chk("cleared", irq, 1'b0);
    bus_wr(`ADDR_CMD, 12'h087);
    bus_wr(`ADDR_CMD, 12'h587);
    bus_rd(`ADDR_IRQ_STAT, d);
    chk("busy", d & 12'h002, 12'h002);
    chk("busy keeps", forward_motion_ff, 8'h01);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset stops", forward_motion_ff | irq, 8'h00);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    report_and_stop;
  end
endmodule
